// ===== rtl/mls_map.svh
// register offsets, widths, reset values and scan constants for the link statistics block
`ifndef MLS_MAP_SVH
`define MLS_MAP_SVH

// register selector codes on the host command port
`define MLS_REG_LAST_RSSI   4'h0
`define MLS_REG_ACK_TMO     4'h1
`define MLS_REG_BLOCKED     4'h2
`define MLS_REG_TX_BYTES    4'h3
`define MLS_REG_GOOD_FRAME  4'h4
`define MLS_REG_TX_FAIL     4'h5
`define MLS_REG_UNI_ATTEMPT 4'h6
`define MLS_REG_CCA_THRESH  4'h7
`define MLS_REG_RETRY_SET   4'h8

// reset values and limits
`define MLS_CNT16_RESET     16'h0000
`define MLS_CNT16_MAX       16'hffff
`define MLS_CNT32_RESET     32'h00000000
`define MLS_RSSI_RESET      8'h00
`define MLS_CCA_OFF         8'h00
`define MLS_RETRY_RESET     8'h00

// energy scan: channel count and characters
`define MLS_NUM_CHAN        16
`define MLS_CHAN_W          4
`define MLS_CHAR_COMMA      8'h2c
`define MLS_CHAR_CR         8'h0d
`define MLS_ENERGY_FLOOR    8'hff

`endif

// ===== rtl/mls_pkg.sv
// types shared by the link statistics block
package mls_pkg;

	// one host command: write selects load, else read
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  sel;
		logic [31:0] data;
	} mls_cmd_t;

	// one answer to a host read
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} mls_rsp_t;

	// events reported by the transmit and receive engines
	typedef struct packed {
		logic       rxFrame;
		logic       rxIsAck;
		logic [7:0] rxRssi;
		logic       ackTimeout;
		logic       txBlockedCca;
		logic       txBlockedRx;
		logic       txByte;
		logic       txRetriesOut;
		logic       txUnicastAck;
	} mls_evt_t;

	// one energy sample for the channel being scanned
	typedef struct packed {
		logic       valid;
		logic [7:0] level;
	} mls_nrg_t;

	typedef enum logic [1:0] {
		SCAN_IDLE,
		SCAN_MEASURE,
		SCAN_VALUE,
		SCAN_SEP
	} mls_scan_t;

endpackage : mls_pkg

// ===== rtl/mls_link_stats.sv
// link statistics counters, signal strength and energy scan for the mesh MAC
//
// How it works
// - hold last received non-ack frame strength, 8 bits
// - strength reads zero until first packet
// - ack timeout counter counts every timeout
// - timeout, good, failure counters saturate at max
// - blocked counter counts CCA or receive blocks
// - threshold zero: only receive blocks counted
// - blocked counter saturates, host may overwrite
// - byte counter adds every transmitted byte
// - byte counter 32 bits, host writable
// - 16-bit event counters host loadable
// - all values start from zero
// - good counter counts valid received frames
// - received acks do not count good
// - failure counter counts exhausted retries
// - attempt counter counts acked unicasts only while retry setting nonzero, resets zero
// - scan every channel, comma each, CR ends
// - scan parameter accepted but ignored
// - withhold transmit when energy above threshold
`timescale 1ns/1ps
`include "mls_map.svh"

module mls_link_stats
	import mls_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire mls_cmd_t    hostCmd,
	output mls_rsp_t         hostRsp,
	input  wire mls_evt_t    macEvt,
	input  wire logic        txCcaReq,
	input  wire logic [7:0]  txCcaEnergy,
	output logic             txCcaDone,
	output logic             txCcaBlock,
	input  wire logic        scanReq,
	input  wire logic [7:0]  scanParam,
	input  wire mls_nrg_t    scanEnergy,
	output logic [`MLS_CHAN_W-1:0] scanChan,
	output logic             scanMeasure,
	output logic             scanCharValid,
	output logic [7:0]       scanChar,
	output logic             scanBusy
);

	// ----------------------------------------------------------------
	// host write decode
	// ----------------------------------------------------------------
	// one strobe per writable register; sel 0 has none, so such writes fall away
	// the read path has no strobe; it is decoded at the mux below
	wire logic wrCmd = hostCmd.valid & hostCmd.write;
	wire logic wrAck = wrCmd & (hostCmd.sel == `MLS_REG_ACK_TMO);
	wire logic wrBlk = wrCmd & (hostCmd.sel == `MLS_REG_BLOCKED);
	wire logic wrByt = wrCmd & (hostCmd.sel == `MLS_REG_TX_BYTES);
	wire logic wrGood = wrCmd & (hostCmd.sel == `MLS_REG_GOOD_FRAME);
	wire logic wrFail = wrCmd & (hostCmd.sel == `MLS_REG_TX_FAIL);
	wire logic wrUni = wrCmd & (hostCmd.sel == `MLS_REG_UNI_ATTEMPT);
	wire logic wrCca = wrCmd & (hostCmd.sel == `MLS_REG_CCA_THRESH);
	wire logic wrRetry = wrCmd & (hostCmd.sel == `MLS_REG_RETRY_SET);
	// scanParam is taken on its port but feeds no logic at all, so the
	// scan length and the reported values are the same for every value;
	// the scan start below carries that rule

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0]  ccaThresh_q;
	logic [7:0]  retrySet_q;

	// only the low byte is kept; thresholds 1 to 0x27 are not refused here
	// threshold and retry setting steer blocking and unicast counting
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			ccaThresh_q <= `MLS_CCA_OFF;
			retrySet_q  <= `MLS_RETRY_RESET;
		end
		else
		begin
			if (wrCca)
				ccaThresh_q <= hostCmd.data[7:0];
			if (wrRetry)
				retrySet_q <= hostCmd.data[7:0];
		end
	end

	// ----------------------------------------------------------------
	// clear channel check
	// ----------------------------------------------------------------
	wire logic ccaEnabled = (ccaThresh_q != `MLS_CCA_OFF);
	// energy in -dBm: a smaller magnitude means a stronger signal
	wire logic ccaBusy = ccaEnabled & (txCcaEnergy < ccaThresh_q);

	// answer is registered, one cycle after the request;
	// txCcaBlock only means something while txCcaDone is high
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			txCcaDone  <= 1'b0;
			txCcaBlock <= 1'b0;
		end
		else
		begin
			txCcaDone  <= txCcaReq;
			txCcaBlock <= txCcaReq & ccaBusy;
		end
	end

	// ----------------------------------------------------------------
	// event counters
	// ----------------------------------------------------------------
	logic [7:0]  lastRssi_q;
	logic [15:0] ackTmo_q;
	logic [15:0] blocked_q;
	logic [31:0] txBytes_q;
	logic [15:0] goodFrame_q;
	logic [15:0] txFail_q;
	logic [15:0] uniAttempt_q;

	// cca blocks are ignored while the check is disabled
	wire logic blkEvt = macEvt.txBlockedRx
		| (macEvt.txBlockedCca & ccaEnabled);
	// strength follows only frames that count as good, so acks leave it alone
	wire logic goodEvt = macEvt.rxFrame & ~macEvt.rxIsAck;
	wire logic uniEvt = macEvt.txUnicastAck & (retrySet_q != `MLS_RETRY_RESET);

	// unicast and byte counters wrap; the other counters stop at all ones
	// saturating increments, one per event
	wire logic [15:0] ackTmo_d = (macEvt.ackTimeout && ackTmo_q != `MLS_CNT16_MAX)
		? ackTmo_q + 16'h0001 : ackTmo_q;
	wire logic [15:0] blocked_d = (blkEvt && blocked_q != `MLS_CNT16_MAX)
		? blocked_q + 16'h0001 : blocked_q;
	wire logic [15:0] goodFrame_d = (goodEvt && goodFrame_q != `MLS_CNT16_MAX)
		? goodFrame_q + 16'h0001 : goodFrame_q;
	wire logic [15:0] txFail_d = (macEvt.txRetriesOut && txFail_q != `MLS_CNT16_MAX)
		? txFail_q + 16'h0001 : txFail_q;
	// attempt counter is not saturating; it wraps like a plain count
	wire logic [15:0] uniAttempt_d = uniEvt ? uniAttempt_q + 16'h0001 : uniAttempt_q;
	// byte counter wraps at 32 bits
	wire logic [31:0] txBytes_d = macEvt.txByte ? txBytes_q + 32'h00000001 : txBytes_q;

	// host load takes priority over a same-cycle event
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			lastRssi_q   <= `MLS_RSSI_RESET;
			ackTmo_q     <= `MLS_CNT16_RESET;
			blocked_q    <= `MLS_CNT16_RESET;
			txBytes_q    <= `MLS_CNT32_RESET;
			goodFrame_q  <= `MLS_CNT16_RESET;
			txFail_q     <= `MLS_CNT16_RESET;
			uniAttempt_q <= `MLS_CNT16_RESET;
		end
		else
		begin
			if (goodEvt)
				lastRssi_q <= macEvt.rxRssi;
			ackTmo_q     <= wrAck  ? hostCmd.data[15:0] : ackTmo_d;
			blocked_q    <= wrBlk  ? hostCmd.data[15:0] : blocked_d;
			txBytes_q    <= wrByt  ? hostCmd.data : txBytes_d;
			goodFrame_q  <= wrGood ? hostCmd.data[15:0] : goodFrame_d;
			txFail_q     <= wrFail ? hostCmd.data[15:0] : txFail_d;
			uniAttempt_q <= wrUni  ? hostCmd.data[15:0] : uniAttempt_d;
		end
	end

	// ----------------------------------------------------------------
	// host read mux
	// ----------------------------------------------------------------
	logic [31:0] rdData;

	// unmapped selectors read zero rather than a stale value
	always_comb
	begin
		case (hostCmd.sel)
			`MLS_REG_LAST_RSSI:   rdData = {24'h000000, lastRssi_q};
			`MLS_REG_ACK_TMO:     rdData = {16'h0000, ackTmo_q};
			`MLS_REG_BLOCKED:     rdData = {16'h0000, blocked_q};
			`MLS_REG_TX_BYTES:    rdData = txBytes_q;
			`MLS_REG_GOOD_FRAME:  rdData = {16'h0000, goodFrame_q};
			`MLS_REG_TX_FAIL:     rdData = {16'h0000, txFail_q};
			`MLS_REG_UNI_ATTEMPT: rdData = {16'h0000, uniAttempt_q};
			`MLS_REG_CCA_THRESH:  rdData = {24'h000000, ccaThresh_q};
			`MLS_REG_RETRY_SET:   rdData = {24'h000000, retrySet_q};
			default:              rdData = 32'h00000000;
		endcase
	end

	// data moves every cycle; only valid marks a real answer
	// reads answer one cycle after the command
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			hostRsp <= '0;
		else
		begin
			hostRsp.valid <= hostCmd.valid & ~hostCmd.write;
			hostRsp.data  <= rdData;
		end
	end

	// ----------------------------------------------------------------
	// energy detect scan
	// ----------------------------------------------------------------
	mls_scan_t                 scanSt_q;
	logic [`MLS_CHAN_W-1:0]    chan_q;
	logic [7:0]                peak_q;
	logic                      crPend_q;    // CR owed after the last comma

	// stronger energy is the smaller -dBm magnitude
	wire logic [7:0] peak_d = (scanEnergy.level < peak_q) ? scanEnergy.level : peak_q;
	wire logic lastChan = (chan_q == `MLS_CHAN_W'(`MLS_NUM_CHAN - 1));
	// a request during a scan is ignored; the running scan finishes
	wire logic scanStart = scanReq & (scanSt_q == SCAN_IDLE);

	// walk all channels: measure, emit value, emit comma; CR follows the last comma
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			scanSt_q      <= SCAN_IDLE;
			chan_q        <= '0;
			peak_q        <= `MLS_ENERGY_FLOOR;
			scanCharValid <= 1'b0;
			scanChar      <= 8'h00;
		end
		else
		begin
			scanCharValid <= 1'b0;
			case (scanSt_q)
				SCAN_IDLE:
				begin
					chan_q <= '0;
					peak_q <= `MLS_ENERGY_FLOOR;
					// the list ends here, one cycle after the last comma
					if (crPend_q)
					begin
						scanCharValid <= 1'b1;
						scanChar      <= `MLS_CHAR_CR;
					end
					if (scanStart)
						scanSt_q <= SCAN_MEASURE;
				end
				SCAN_MEASURE:
				begin
					// waits as long as the source needs; there is no timeout
					if (scanEnergy.valid)
					begin
						peak_q   <= peak_d;
						scanSt_q <= SCAN_VALUE;
					end
				end
				SCAN_VALUE:
				begin
					// one raw byte per channel; text formatting is left to the host
					scanCharValid <= 1'b1;
					scanChar      <= peak_q;
					scanSt_q      <= SCAN_SEP;
				end
				SCAN_SEP:
				begin
					scanCharValid <= 1'b1;
					scanChar      <= `MLS_CHAR_COMMA;
					peak_q        <= `MLS_ENERGY_FLOOR;
					// chan_q rolls over to zero by itself after the last channel
					chan_q        <= chan_q + `MLS_CHAN_W'(1);
					scanSt_q      <= lastChan ? SCAN_IDLE : SCAN_MEASURE;
				end
				default:
					scanSt_q <= SCAN_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// scan status outputs
	// ----------------------------------------------------------------
	// CR is owed one cycle after the last comma; busy covers that cycle

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			crPend_q    <= 1'b0;
			scanChan    <= '0;
			scanMeasure <= 1'b0;
			scanBusy    <= 1'b0;
		end
		else
		begin
			crPend_q    <= (scanSt_q == SCAN_SEP) & lastChan;
			scanChan    <= chan_q;
			scanMeasure <= (scanSt_q == SCAN_MEASURE);
			scanBusy    <= (scanSt_q != SCAN_IDLE) | crPend_q | scanStart;
		end
	end

endmodule : mls_link_stats

// ===== bench/mls_link_stats_sva.sv
// port-level assertions for the link statistics block
`timescale 1ns/1ps
module mls_link_stats_sva
	import mls_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire mls_cmd_t   hostCmd,
	input wire mls_rsp_t   hostRsp,
	input wire logic       txCcaReq,
	input wire logic       txCcaDone,
	input wire logic       scanReq,
	input wire logic       scanMeasure,
	input wire logic       scanCharValid,
	input wire logic [7:0] scanChar,
	input wire logic       scanBusy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// a host read request, and a scan value that is not a separator
	sequence s_read;
		hostCmd.valid && !hostCmd.write;
	endsequence
	sequence s_value_char;
		scanCharValid && scanChar != 8'h2c && scanChar != 8'h0d;
	endsequence

	a_read_answered: assert property (
		s_read |=> hostRsp.valid) else $error("read not answered");
	a_answer_caused: assert property (
		hostRsp.valid |-> $past(hostCmd.valid) && !$past(hostCmd.write))
		else $error("answer without read");
	a_write_silent: assert property (
		hostCmd.valid && hostCmd.write |=> !hostRsp.valid) else $error("write answered");
	a_upper_clear: assert property (
		s_read ##0 hostCmd.sel == 4'h1 |=> hostRsp.data[31:16] == 16'h0)
		else $error("counter upper bits set");
	a_cca_answer: assert property (
		txCcaReq |=> txCcaDone) else $error("cca not answered");
	a_cca_caused: assert property (
		txCcaDone |-> $past(txCcaReq)) else $error("cca done unasked");
	a_scan_starts: assert property (
		scanReq && !scanBusy |-> ##[1:2] scanBusy) else $error("scan not started");
	a_measure_busy: assert property (
		scanMeasure |-> scanBusy) else $error("measure while idle");
	a_comma_follows: assert property (
		s_value_char |=> scanCharValid && scanChar == 8'h2c) else $error("no comma");
endmodule : mls_link_stats_sva

// ===== bench/mls_host_model.sv
// host processor model issuing register writes and reads
`timescale 1ns/1ps
module mls_host_model
	import mls_pkg::*;
(
	input  wire logic     ref_clk,
	output mls_cmd_t      hostCmd,
	input  wire mls_rsp_t hostRsp
);
	initial hostCmd = '0;

	// request held across the taking edge, then dropped
	task automatic wr(input logic [3:0] sel, input logic [31:0] d);
		@(posedge ref_clk) hostCmd <= '{1'b1, 1'b1, sel, d};
		@(posedge ref_clk) hostCmd <= '0;
	endtask : wr

	// answer is a one-cycle pulse, so look mid-cycle
	task automatic rd(input logic [3:0] sel, output logic [31:0] d);
		@(posedge ref_clk) hostCmd <= '{1'b1, 1'b0, sel, 32'h0};
		@(posedge ref_clk) hostCmd <= '0;
		@(negedge ref_clk) d = hostRsp.valid ? hostRsp.data : 32'hxxxxxxxx;
	endtask : rd
endmodule : mls_host_model

// ===== bench/mls_link_stats_test.sv
// self-checking bench for the link statistics block
`timescale 1ns/1ps
`include "mls_map.svh"
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errTotal++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module mls_link_stats_test
	import mls_pkg::*;
;
	logic                  ref_clk     = 1'b0;
	logic                  reset       = 1'b1;
	mls_cmd_t              hostCmd;
	mls_rsp_t              hostRsp;
	mls_evt_t              macEvt      = '0;
	logic                  txCcaReq    = 1'b0;
	logic [7:0]            txCcaEnergy = 8'h00;
	logic                  txCcaDone;
	logic                  txCcaBlock;
	logic                  scanReq     = 1'b0;
	logic [7:0]            scanParam   = 8'h00;
	mls_nrg_t              scanEnergy  = '0;
	logic [`MLS_CHAN_W-1:0] scanChan;
	logic                  scanMeasure;
	logic                  scanCharValid;
	logic [7:0]            scanChar;
	logic                  scanBusy;
	int                    errTotal    = 0;
	int                    nCompared   = 0;
	logic [31:0]           rdat;
	logic [3:0]            sats[4]     = '{4'h1, 4'h2, 4'h4, 4'h5};

	mls_link_stats uut (.*);
	mls_host_model host (.*);

	always #2.5 ref_clk = ~ref_clk;

	// energy source pulses valid on alternate cycles while measure is high; idle level keeps moving
	always @(posedge ref_clk)
		scanEnergy <= '{scanMeasure && !scanEnergy.valid,
			scanMeasure ? 8'h40 + {4'h0, scanChan} : ~scanEnergy.level};

	// ------------------------------------------------------------
	// shared drivers
	// ------------------------------------------------------------
	task automatic expect_rd(input logic [3:0] s, input logic [31:0] w);
		host.rd(s, rdat);
		`CHK(rdat, w)
	endtask : expect_rd

	task automatic pulse(input mls_evt_t e);
		@(posedge ref_clk) macEvt <= e;
		@(posedge ref_clk) macEvt <= '0;
	endtask : pulse

	task automatic cca(input logic [7:0] en, input logic blk);
		@(posedge ref_clk);
		txCcaReq <= 1'b1;
		txCcaEnergy <= en;
		@(posedge ref_clk);
		txCcaReq <= 1'b0;
		@(negedge ref_clk);
		`CHK({txCcaDone, txCcaBlock}, {1'b1, blk})
	endtask : cca

	task automatic conclude;
		if (errTotal == 0 && nCompared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// everything reads zero, unmapped place included
	task automatic t_reset;
		for (int s = 0; s < 10; s++)
			expect_rd(4'(s), 32'h0);
	endtask : t_reset

	task automatic t_events;
		pulse('{ackTimeout: 1'b1, default: '0});
		expect_rd(`MLS_REG_ACK_TMO, 32'h1);
		pulse('{txBlockedRx: 1'b1, default: '0});
		pulse('{txBlockedCca: 1'b1, default: '0});
		expect_rd(`MLS_REG_BLOCKED, 32'h1);
		host.wr(`MLS_REG_CCA_THRESH, 32'h28);
		pulse('{txBlockedCca: 1'b1, default: '0});
		expect_rd(`MLS_REG_BLOCKED, 32'h2);
		repeat (3) pulse('{txByte: 1'b1, default: '0});
		expect_rd(`MLS_REG_TX_BYTES, 32'h3);
		pulse('{rxFrame: 1'b1, rxRssi: 8'h60, default: '0});
		pulse('{rxFrame: 1'b1, rxIsAck: 1'b1, rxRssi: 8'h22, default: '0});
		expect_rd(`MLS_REG_GOOD_FRAME, 32'h1);
		expect_rd(`MLS_REG_LAST_RSSI, 32'h60);
		pulse('{txRetriesOut: 1'b1, default: '0});
		expect_rd(`MLS_REG_TX_FAIL, 32'h1);
		pulse('{txUnicastAck: 1'b1, default: '0});
		expect_rd(`MLS_REG_UNI_ATTEMPT, 32'h0);
		host.wr(`MLS_REG_RETRY_SET, 32'h1);
		pulse('{txUnicastAck: 1'b1, default: '0});
		expect_rd(`MLS_REG_UNI_ATTEMPT, 32'h1);
	endtask : t_events

	// saturation, host loads, read-only strength, write beats event
	task automatic t_limits;
		foreach (sats[i]) host.wr(sats[i], 32'hffff);
		pulse('{ackTimeout: 1'b1, txBlockedRx: 1'b1, rxFrame: 1'b1, rxRssi: 8'h7a,
			txRetriesOut: 1'b1, default: '0});
		foreach (sats[i]) expect_rd(sats[i], 32'hffff);
		host.wr(`MLS_REG_BLOCKED, 32'h0);
		expect_rd(`MLS_REG_BLOCKED, 32'h0);
		host.wr(`MLS_REG_TX_BYTES, 32'hdeadbeef);
		expect_rd(`MLS_REG_TX_BYTES, 32'hdeadbeef);
		host.wr(`MLS_REG_LAST_RSSI, 32'h11);
		expect_rd(`MLS_REG_LAST_RSSI, 32'h7a);
		fork
			host.wr(`MLS_REG_ACK_TMO, 32'h1234);
			pulse('{ackTimeout: 1'b1, default: '0});
		join
		expect_rd(`MLS_REG_ACK_TMO, 32'h1234);
	endtask : t_limits

	task automatic t_cca;
		cca(8'h20, 1'b1);
		cca(8'h30, 1'b0);
		host.wr(`MLS_REG_CCA_THRESH, 32'h0);
		cca(8'h20, 1'b0);
	endtask : t_cca

	// bounded wait: a missing terminator must not hang the run
	task automatic t_scan(input logic [7:0] prm);
		logic [7:0] q[$];
		int         n;
		n = 0;
		@(posedge ref_clk);
		scanReq <= 1'b1;
		scanParam <= prm;
		@(posedge ref_clk);
		scanReq <= 1'b0;
		while ((q.size() < 33 || scanBusy !== 1'b0) && n < 600)
		begin
			@(negedge ref_clk);
			n++;
			if (scanCharValid === 1'b1)
				q.push_back(scanChar);
		end
		`CHK(q.size(), 33)
		for (int i = 0; i < 32; i++)
			`CHK(q[i], i[0] ? `MLS_CHAR_COMMA : 8'h40 + 8'(i / 2))
		`CHK(q[32], `MLS_CHAR_CR)
	endtask : t_scan

	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_events();
		t_limits();
		t_cca();
		t_scan(8'h00);
		t_scan(8'hff);
		conclude();
	end

	// watchdog well beyond the expected few hundred cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errTotal++;
		conclude();
	end
endmodule : mls_link_stats_test

bind mls_link_stats mls_link_stats_sva chk (.*);
